// [verilog/smbus_defs.svh]
// constants for the two-wire control and status register
`ifndef SMBUS_DEFS_SVH
`define SMBUS_DEFS_SVH
// special function address of the control and status register
`define BCS_ADDR 8'hC0
// register reset value
`define BCS_RESET 8'h00
// bit positions inside the register
`define BCS_MASTER 3'h7
`define BCS_TX 3'h6
`define BCS_BEGIN 3'h5
`define BCS_END 3'h4
`define BCS_REPLY_REQ 3'h3
`define BCS_ARB 3'h2
`define BCS_ACK 3'h1
`define BCS_SI 3'h0
// bit address base for single-bit writes (upper five bits)
`define BCS_BIT_BASE 5'h18
`endif

// [verilog/smbus_pkg.sv]
// shared types for the two-wire control and status block
package smbus_pkg;
  // register image, bit 7 first
  typedef struct packed {
    logic master;
    logic transmit_indicator;
    logic begin_condition_flag;
    logic end_condition_flag;
    logic reply_request;
    logic arbitration_lost_flag;
    logic ack;
    logic si;
  } bcs_s;
  // one-cycle events and levels from the byte engine
  typedef struct packed {
    logic start_gen;
    logic stop_gen;
    logic frame_start;
    logic data_wr;
    logic byte_sent;
    logic byte_rcvd;
    logic addr_rcvd;
    logic ack_done;
    logic ack_in;
    logic addressed;
    logic cond_gen;
    logic tx_one;
  } bus_evt_s;
  // bus condition the engine is asked to make
  typedef enum logic [1:0] {
    req_none,
    req_start,
    req_stop,
    req_stop_start
  } cond_req_e;
endpackage

// [verilog/smbus_control_status.sv]
// control and status register of the two-wire serial interface
`timescale 1ns/1ns
`include "smbus_defs.svh"

module smbus_control_status (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_wr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_bit_wr,
  input  wire logic [7:0]          sfr_bit_addr,
  input  wire logic                sfr_bit_val,
  input  wire logic                sfr_rd,
  output logic [7:0]               sfr_rdata,
  input  wire smbus_pkg::bus_evt_s evt,
  input  wire logic                auto_reply_enable,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     scl_out,
  output logic                     scl_oe,
  output logic                     reply_level,
  output smbus_pkg::cond_req_e     cond_req,
  output logic                     next_event
);

  // register state
  smbus_pkg::bcs_s bcs_reg;      // live register image
  logic [7:0]      rdata_reg;    // read data, one cycle after sfr_rd
  logic            ack_wr_reg;   // software wrote ack since request
  logic            dat_wr_reg;   // shift data written before frame
  // pin synchronisers and edge history
  logic            scl_meta;     // first stage, read only by scl_sync
  logic            scl_sync;     // second stage
  logic            scl_prev;     // previous synced level
  logic            sda_meta;     // first stage, read only by sda_sync
  logic            sda_sync;     // second stage
  logic            sda_prev;     // previous synced level
  // decoded software writes
  logic [7:0]      wr_mask;      // bits touched by this write
  logic [7:0]      wr_val;       // values written
  // bus conditions seen on the pins
  logic            start_det;    // sda falls while scl high
  logic            stop_det;     // sda rises while scl high
  // hardware set terms and the software clear of SI
  logic            arb_set;
  logic            si_set;
  logic            si_sw_clr;
  // every check below runs on the system clock and sleeps through reset
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // byte write or single bit write, merged into mask and value
  function automatic logic [15:0] write_decode(
    input logic       byte_wr,
    input logic [7:0] addr,
    input logic [7:0] data,
    input logic       bit_wr,
    input logic [7:0] baddr,
    input logic       bval
  );
    logic [7:0] m;
    logic [7:0] v;
    m = 8'h00;
    v = 8'h00;
    if (byte_wr && addr == `BCS_ADDR) begin
      m = 8'hFF;
      v = data;
    end else if (bit_wr && baddr[7:3] == `BCS_BIT_BASE) begin
      m[baddr[2:0]] = 1'b1;
      v[baddr[2:0]] = bval;
    end
    return {m, v};
  endfunction

  always_comb begin
    {wr_mask, wr_val} = write_decode(sfr_wr, sfr_addr, sfr_wdata,
                                     sfr_bit_wr, sfr_bit_addr, sfr_bit_val);
  end

  // two flip-flops on each pin before any logic looks at it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // start and stop seen on the bus; link clock is sampled, not used as clock
  assign start_det = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_det  = scl_sync && scl_prev && !sda_prev && sda_sync;

  // unwanted repeated start, scl low during a condition, sda mismatch, unwanted stop
  assign arb_set = (start_det && bcs_reg.master && !bcs_reg.begin_condition_flag
                    && !evt.start_gen)
                 || (evt.cond_gen && !scl_sync)
                 || (evt.tx_one && !sda_sync)
                 || (stop_det && bcs_reg.master && !evt.stop_gen);

  assign si_set = evt.start_gen || arb_set || evt.byte_sent || evt.byte_rcvd
               || evt.addr_rcvd || (stop_det && evt.addressed);

  assign si_sw_clr = wr_mask[`BCS_SI] && !wr_val[`BCS_SI] && bcs_reg.si;

  // master indicator
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.master <= 1'b0;
    end else if (evt.start_gen) begin
      bcs_reg.master <= 1'b1;
    end else if (evt.stop_gen || arb_set) begin
      bcs_reg.master <= 1'b0;
    end
  end

  // data-written marker; a write in the frame-start cycle is used by that frame, not the next
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_wr_reg <= 1'b0;
    end else if (evt.frame_start) begin
      dat_wr_reg <= 1'b0;
    end else if (evt.data_wr) begin
      dat_wr_reg <= 1'b1;
    end
  end

  // transmit indicator; set terms win over clear terms
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.transmit_indicator <= 1'b0;
    end else if (evt.start_gen) begin
      bcs_reg.transmit_indicator <= 1'b1;
    end else if (evt.frame_start) begin
      bcs_reg.transmit_indicator <= dat_wr_reg || evt.data_wr;
    end else if (start_det || arb_set) begin
      bcs_reg.transmit_indicator <= 1'b0;
    end
  end

  // begin flag: hardware only sets, software writes either way
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.begin_condition_flag <= 1'b0;
    end else if (evt.addr_rcvd) begin
      bcs_reg.begin_condition_flag <= 1'b1;
    end else if (wr_mask[`BCS_BEGIN]) begin
      bcs_reg.begin_condition_flag <= wr_val[`BCS_BEGIN];
    end
  end

  // end flag: set on slave stop or stop-caused loss, cleared once sent
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.end_condition_flag <= 1'b0;
    end else if ((stop_det && evt.addressed) || (stop_det && arb_set)) begin
      bcs_reg.end_condition_flag <= 1'b1;
    end else if (evt.stop_gen) begin
      bcs_reg.end_condition_flag <= 1'b0;
    end else if (wr_mask[`BCS_END]) begin
      bcs_reg.end_condition_flag <= wr_val[`BCS_END];
    end
  end

  // reply request only in software acknowledge mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.reply_request <= 1'b0;
    end else if (evt.byte_rcvd && !auto_reply_enable) begin
      bcs_reg.reply_request <= 1'b1;
    end else if (evt.ack_done) begin
      bcs_reg.reply_request <= 1'b0;
    end
  end

  // arbitration lost: a new loss wins over the clear that rides on SI
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.arbitration_lost_flag <= 1'b0;
    end else if (arb_set) begin
      bcs_reg.arbitration_lost_flag <= 1'b1;
    end else if (si_sw_clr) begin
      bcs_reg.arbitration_lost_flag <= 1'b0;
    end
  end

  // acknowledge: received value when transmitting, outgoing value when written
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.ack <= 1'b0;
    end else if (evt.ack_done && bcs_reg.transmit_indicator) begin
      bcs_reg.ack <= !evt.ack_in;
    end else if (wr_mask[`BCS_ACK]) begin
      bcs_reg.ack <= wr_val[`BCS_ACK];
    end
  end

  // remembers whether software answered the current reply request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_wr_reg <= 1'b0;
    end else if (evt.ack_done || evt.byte_rcvd) begin
      ack_wr_reg <= 1'b0;
    end else if (wr_mask[`BCS_ACK]) begin
      ack_wr_reg <= 1'b1;
    end
  end

  // interrupt flag: hardware set wins over a software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcs_reg.si <= 1'b0;
    end else if (si_set) begin
      bcs_reg.si <= 1'b1;
    end else if (wr_mask[`BCS_SI]) begin
      bcs_reg.si <= wr_val[`BCS_SI];
    end
  end

  // read data from flops, one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= `BCS_RESET;
    end else if (sfr_rd && sfr_addr == `BCS_ADDR) begin
      rdata_reg <= bcs_reg;
    end
  end
  assign sfr_rdata = rdata_reg;

  // stall by holding the clock line low while SI is set
  assign scl_out = 1'b0;
  assign scl_oe  = bcs_reg.si;

  // software mode sends nack unless ack was written
  assign reply_level = (auto_reply_enable || ack_wr_reg) ? bcs_reg.ack : 1'b0;

  // one-cycle pulse that lets the byte engine take its next step
  assign next_event = si_sw_clr && !si_set;

  // condition request; nothing is asked while stalled
  always_comb begin
    cond_req = smbus_pkg::req_none;
    if (!bcs_reg.si) begin
      if (bcs_reg.master && bcs_reg.end_condition_flag && bcs_reg.begin_condition_flag) begin
        cond_req = smbus_pkg::req_stop_start;
      end else if (bcs_reg.master && bcs_reg.end_condition_flag) begin
        cond_req = smbus_pkg::req_stop;
      end else if (bcs_reg.begin_condition_flag) begin
        cond_req = smbus_pkg::req_start;
      end
    end
  end

  // checks on the register behaviour, clocked and disabled by the defaults above
  property p_master_set;
    evt.start_gen |=> bcs_reg.master;
  endproperty
  a_master_set: assert property (p_master_set) else $error("master not set");
  property p_tx_clr;
    (arb_set && !evt.start_gen && !evt.frame_start) |=> !bcs_reg.transmit_indicator;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx not cleared");
  property p_begin_hold;
    (bcs_reg.begin_condition_flag && !wr_mask[`BCS_BEGIN]) |=> bcs_reg.begin_condition_flag;
  endproperty
  a_begin_hold: assert property (p_begin_hold) else $error("begin flag lost");
  property p_stop_req;
    (bcs_reg.master && bcs_reg.end_condition_flag && !bcs_reg.begin_condition_flag
      && !bcs_reg.si) |-> cond_req == smbus_pkg::req_stop;
  endproperty
  a_stop_req: assert property (p_stop_req) else $error("stop not asked");
  property p_no_request;
    (evt.byte_rcvd && auto_reply_enable && !bcs_reg.reply_request) |=> !bcs_reg.reply_request;
  endproperty
  a_no_request: assert property (p_no_request) else $error("reply request in auto mode");
  property p_arb_clr;
    (si_sw_clr && !si_set) |=> !bcs_reg.arbitration_lost_flag && !bcs_reg.si;
  endproperty
  a_arb_clr: assert property (p_arb_clr) else $error("arb not cleared");
  property p_si_stall;
    si_set |=> scl_oe && cond_req == smbus_pkg::req_none;
  endproperty
  a_si_stall: assert property (p_si_stall) else $error("bus not stalled");
  property p_si_sticky;
    (bcs_reg.si && !wr_mask[`BCS_SI]) |=> bcs_reg.si;
  endproperty
  a_si_sticky: assert property (p_si_sticky) else $error("si cleared by hw");
  property p_nack_default;
    (evt.byte_rcvd && !auto_reply_enable) ##1 (!wr_mask[`BCS_ACK] && !auto_reply_enable)
      |-> !reply_level;
  endproperty
  a_nack_default: assert property (p_nack_default) else $error("ack without write");
  property p_both_flags;
    (bcs_reg.master && bcs_reg.end_condition_flag && bcs_reg.begin_condition_flag
      && !bcs_reg.si) |-> cond_req == smbus_pkg::req_stop_start;
  endproperty
  a_both_flags: assert property (p_both_flags) else $error("no stop-start");

  // main scenarios
  c_start: cover property (evt.start_gen ##1 bcs_reg.master && bcs_reg.si);
  c_arb: cover property (arb_set ##[1:20] si_sw_clr);
  c_stop: cover property (cond_req == smbus_pkg::req_stop ##[1:50] evt.stop_gen);

endmodule

// [bench/bus_peer.sv]
// far-side two-wire bus device: start, byte and stop frames
`timescale 1ns/1ns

module bus_peer (
  input  wire logic scl_line, // wired level of the clock line
  output logic      scl_drv,  // 0 pulls low, 1 releases to pull-up
  output logic      sda_drv   // 0 pulls low, 1 releases to pull-up
);
  // both lines released at rest; the clock stands still between frames
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // release the clock and wait while the device stretches it low
  task automatic rise();
    scl_drv = 1'b1;
    wait (scl_line === 1'b1);
    #80;
  endtask

  // start, eight bits msb first, low ack slot, then stop; 160 ns bit time
  task automatic frame(input logic [7:0] b);
    logic [7:0] sh;
    sh = b;
    #5;
    sda_drv = 1'b0;
    #80;
    for (int j = 0; j < 9; j++) begin
      scl_drv = 1'b0;
      #40;
      sda_drv = sh[7];
      sh = {sh[6:0], 1'b0};
      #40;
      rise();
    end
    scl_drv = 1'b0;
    #80;
    rise();
    sda_drv = 1'b1;
    #80;
  endtask

  // drag data low while the clock is low, so no start or stop is seen
  task automatic pull_sda();
    #5;
    scl_drv = 1'b0;
    #40;
    sda_drv = 1'b0;
    #120;
    sda_drv = 1'b1;
    #40;
    scl_drv = 1'b1;
  endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the two-wire control and status register
`timescale 1ns/1ns

module testbench;
  logic                 clk_sys = 1'b0;      // 50 MHz system clock
  logic                 rst_n = 1'b0;        // held low at start
  logic [7:0]           sfr_addr = 8'h00;    // register bus
  logic                 sfr_wr = 1'b0;
  logic [7:0]           sfr_wdata = 8'h00;
  logic                 sfr_bit_wr = 1'b0;
  logic [7:0]           sfr_bit_addr = 8'h00;
  logic                 sfr_bit_val = 1'b0;
  logic                 sfr_rd = 1'b0;
  logic [7:0]           sfr_rdata;
  logic                 auto_reply_enable = 1'b0;
  logic                 scl_out;
  logic                 scl_oe;
  logic                 reply_level;
  logic                 next_event;
  logic                 ne = 1'b0;           // next_event seen in strobe cycle
  smbus_pkg::cond_req_e cond_req;
  smbus_pkg::bus_evt_s  pl = '0;             // one-cycle engine pulses
  smbus_pkg::bus_evt_s  lv = '0;             // engine levels
  logic                 peer_scl;
  logic                 peer_sda;
  logic                 scl_line;            // wired-and of both parties
  int                   err_total = 0;
  int                   checks = 0;
  int                   cyc = 0;

  assign scl_line = peer_scl & (scl_out | ~scl_oe);

  always #10 clk_sys = ~clk_sys;

  bus_peer i_peer (.scl_line(scl_line), .scl_drv(peer_scl), .sda_drv(peer_sda));

  smbus_control_status i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .evt(pl | lv),
    .auto_reply_enable(auto_reply_enable), .scl_in(scl_line), .sda_in(peer_sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .reply_level(reply_level),
    .cond_req(cond_req), .next_event(next_event)
  );

  // compare one value and keep the tallies
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // byte write; ends just past the taking edge so state has landed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    #1;
  endtask

  // single-bit write, bit n at base address plus n
  task automatic bw(input logic [2:0] n, input logic v);
    @(posedge clk_sys);
    sfr_bit_addr <= 8'hc0 + {5'h00, n};
    sfr_bit_val <= v;
    sfr_bit_wr <= 1'b1;
    #1 ne = next_event;
    @(posedge clk_sys);
    sfr_bit_wr <= 1'b0;
    #1;
  endtask

  // read the register and compare the returned image
  task automatic rd(input logic [7:0] exp);
    @(posedge clk_sys);
    sfr_addr <= 8'hc0;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    #1 chk("bcs", sfr_rdata, exp);
  endtask

  // one-cycle engine event
  task automatic ev(input smbus_pkg::bus_evt_s p);
    @(posedge clk_sys);
    pl <= p;
    @(posedge clk_sys);
    pl <= '0;
    #1;
  endtask

  // counts, verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard: the sequence needs a few hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h00);
    chk("oe", {7'h00, scl_oe}, 8'h00);
    wr(8'hc1, 8'hff);
    rd(8'h00);
    wr(8'hc0, 8'hff);
    rd(8'h33);
    chk("oe", {7'h00, scl_oe}, 8'h01);
    bw(3'h0, 1'b0);
    chk("next", {7'h00, ne}, 8'h01);
    rd(8'h32);
    wr(8'hc0, 8'h00);
    // master start, then arbitration lost while sending a one
    ev(12'h800);
    rd(8'hc1);
    bw(3'h0, 1'b0);
    lv <= 12'h001;
    i_peer.pull_sda();
    lv <= '0;
    rd(8'h05);
    wr(8'hc0, 8'h00);
    rd(8'h00);
    // condition requests as master, then stop generated
    ev(12'h800);
    wr(8'hc0, 8'h20);
    chk("req", {6'h00, cond_req}, {6'h00, smbus_pkg::req_start});
    wr(8'hc0, 8'h30);
    chk("req", {6'h00, cond_req}, {6'h00, smbus_pkg::req_stop_start});
    wr(8'hc0, 8'h10);
    chk("req", {6'h00, cond_req}, {6'h00, smbus_pkg::req_stop});
    ev(12'h400);
    rd(8'h40);
    // transmit indicator against data writes before frames
    ev(12'h200);
    rd(8'h00);
    ev(12'h100);
    ev(12'h200);
    rd(8'h40);
    // addressed slave sees a whole frame ending in stop
    lv <= 12'h004;
    i_peer.frame(8'ha5);
    rd(8'h11);
    ev(12'h020);
    rd(8'h31);
    lv <= '0;
    wr(8'hc0, 8'h00);
    // software acknowledge path
    ev(12'h040);
    rd(8'h09);
    chk("reply", {7'h00, reply_level}, 8'h00);
    bw(3'h1, 1'b1);
    chk("reply", {7'h00, reply_level}, 8'h01);
    ev(12'h018);
    rd(8'h03);
    // as transmitter the bit reports the incoming acknowledge
    ev(12'h100);
    ev(12'h200);
    ev(12'h018);
    rd(8'h41);
    ev(12'h010);
    rd(8'h43);
    ev(12'h200);
    // hardware acknowledge path, then a sent byte
    wr(8'hc0, 8'h02);
    auto_reply_enable <= 1'b1;
    ev(12'h040);
    rd(8'h03);
    chk("reply", {7'h00, reply_level}, 8'h01);
    wr(8'hc0, 8'h00);
    ev(12'h080);
    rd(8'h01);
    chk("scl", {7'h00, scl_out}, 8'h00);
    // clock line held low by the stall while a condition is being made
    ev(12'h002);
    rd(8'h05);
    summarize();
  end
endmodule
